// ### rtl/dual_bidirectional_io_ports.sv
// What this block does
// R1: Narrow port data bits 6 and 7 read zero and ignore writes.
// R2: Narrow port direction bit 6 reads zero, bit 7 holds the slow-fall enable; all clear on reset.
// R3: Data latches keep their contents across reset.
// R4: Direction bit one makes a line output, zero makes it input.
// R5: All direction bits clear on reset, so every line starts as input.
// R6: Direction bits are readable and writable, except narrow port bit 6.
// R7: Output lines follow the latch; data reads of outputs return the latch.
// R8: Data reads of input lines return the sensed pin level.
// R9: Writes to input line data only update the latch.
// R10: With pull option, pull acts while its disable bit is zero.
// R11: Pull-downs act only on inputs; pull-ups act regardless of direction.
// R12: Pull-disable registers are write-only and clear on reset.
// R13: Software must not read-modify-write the pull-disable registers.
// R14: Slow-fall bit gives slow edges on four open-drain lines when outputs.
// R15: Second wide-sink line falls one whole cycle late; the first falls at once.
// R16: Registers decode at indices 0, 4, 10 hex and 1, 5, 11 hex.
// R17: Narrow line zero feeds the timer capture input.
// R18: Software should load the latch before turning a line to output.
// R19: Software should enable pull-down before turning an output to input.
// R20: Wide port pull-disable is write-only and clears on reset; direction writes leave it unchanged.
// R21: Pull build options are static inputs; deselected means no pulls.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ports_cfg.svh"
module dual_bidirectional_io_ports (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pull_option_enable,
    input wire logic [7:0] port_a_pull_is_up,
    input wire logic [5:0] port_b_pull_is_up,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe_n,
    output logic [7:0] port_a_pull_down_en,
    output logic [7:0] port_a_pull_up_en,
    input wire logic [5:0] port_b_in,
    output logic [5:0] port_b_out,
    output logic [5:0] port_b_oe_n,
    output logic [5:0] port_b_pull_down_en,
    output logic [5:0] port_b_pull_up_en,
    output logic wide_port_line6_slow,
    output logic wide_port_line7_slow,
    output logic wide_sink_line_first_slow,
    output logic timer_capture_input
);
    gpio_ports_pkg::port_byte_t port_a_latch;
    gpio_ports_pkg::port_byte_t port_b_latch;
    gpio_ports_pkg::port_byte_t port_a_direction;
    gpio_ports_pkg::port_byte_t port_b_direction;
    gpio_ports_pkg::port_byte_t port_a_pull_disable;
    gpio_ports_pkg::port_byte_t port_b_pull_disable;
    gpio_ports_pkg::reg_sel_t sel;
    logic [13:0] pins_synced;
    logic [7:0] pins_a;
    logic [5:0] pins_b;
    logic wr_strobe;
    logic rd_strobe;
    logic slow_fall_enable;
    logic [7:0] wr_byte;
    logic second_pending;
    logic [5:0] next_b_out;
    logic [5:0] next_b_oe_n;
    logic setup_phase;
    gpio_ports_pkg::port_byte_t next_prdata;
    gpio_ports_pkg::port_byte_t b_pull_up_full;
    gpio_ports_pkg::port_byte_t b_pull_down_full;

    // Outputs are open-drain on the four slow lines in the pad; here every line
    // is described as a push-pull driver and the pad decides the drive style.
    pin_sync u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .raw({port_b_in, port_a_in}),
        .synced(pins_synced)
    );

    assign pins_a = pins_synced[7:0];
    assign pins_b = pins_synced[13:8];
    assign setup_phase = psel && !penable;
    assign wr_strobe = psel && penable && pwrite && pstrb[0];
    // Read data is captured in the setup cycle so that it stands beside pready.
    assign rd_strobe = setup_phase && !pwrite;
    assign wr_byte = pwdata[7:0];
    assign slow_fall_enable = port_b_direction[`B_SLOW_BIT];

    function automatic gpio_ports_pkg::reg_sel_t decode(input logic [31:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'b00 || addr[31:10] != 22'h000000) begin
            decode = gpio_ports_pkg::SEL_NONE;
        end else if (idx == `IDX_A_LATCH) begin
            decode = gpio_ports_pkg::SEL_A_LATCH; // [R16]
        end else if (idx == `IDX_B_LATCH) begin
            decode = gpio_ports_pkg::SEL_B_LATCH; // [R16]
        end else if (idx == `IDX_A_DIR) begin
            decode = gpio_ports_pkg::SEL_A_DIR; // [R16]
        end else if (idx == `IDX_B_DIR) begin
            decode = gpio_ports_pkg::SEL_B_DIR; // [R16]
        end else if (idx == `IDX_A_PULL) begin
            decode = gpio_ports_pkg::SEL_A_PULL; // [R16]
        end else if (idx == `IDX_B_PULL) begin
            decode = gpio_ports_pkg::SEL_B_PULL; // [R16]
        end else begin
            decode = gpio_ports_pkg::SEL_NONE;
        end
    endfunction : decode

    // Mixes latch and sensed level per bit according to direction.
    function automatic gpio_ports_pkg::port_byte_t data_view(
        input gpio_ports_pkg::port_byte_t latch,
        input gpio_ports_pkg::port_byte_t dir,
        input gpio_ports_pkg::port_byte_t pins
    );
        data_view = (latch & dir) | (pins & ~dir); // [R7] [R8]
    endfunction : data_view

    // Pull-ups act whatever the direction; only the disable bit, the option and the per-line pull-up choice gate them.
    function automatic gpio_ports_pkg::port_byte_t pull_up_mask(
        input logic option,
        input gpio_ports_pkg::port_byte_t off_bits,
        input gpio_ports_pkg::port_byte_t is_up
    );
        pull_up_mask = {8{option}} & ~off_bits & is_up; // [R10] [R11] [R21]
    endfunction : pull_up_mask

    // A pull-down would only load a driven output, so it is dropped while the line drives.
    function automatic gpio_ports_pkg::port_byte_t pull_down_mask(
        input logic option,
        input gpio_ports_pkg::port_byte_t off_bits,
        input gpio_ports_pkg::port_byte_t is_up,
        input gpio_ports_pkg::port_byte_t dir
    );
        pull_down_mask = {8{option}} & ~off_bits & ~is_up & ~dir; // [R10] [R11] [R21]
    endfunction : pull_down_mask

    // True while the second wide-sink line is about to fall with the slow feature on.
    function automatic logic second_line_falling(
        input logic slow,
        input logic dir_bit,
        input logic latch_bit,
        input logic out_bit
    );
        second_line_falling = slow && dir_bit && !latch_bit && out_bit; // [R15]
    endfunction : second_line_falling

    assign sel = decode(paddr);
    // Bits 7 and 6 of the narrow results are computed but never reach a pin.
    assign b_pull_up_full = pull_up_mask(pull_option_enable, port_b_pull_disable,
        {2'b00, port_b_pull_is_up});
    assign b_pull_down_full = pull_down_mask(pull_option_enable, port_b_pull_disable,
        {2'b00, port_b_pull_is_up}, port_b_direction);

    // Latches have no reset so that their contents survive a system reset.
    always_ff @(posedge pclk) begin
        if (wr_strobe && sel == gpio_ports_pkg::SEL_A_LATCH) begin
            port_a_latch <= wr_byte; // [R3] [R9]
        end
    end

    always_ff @(posedge pclk) begin
        if (wr_strobe && sel == gpio_ports_pkg::SEL_B_LATCH) begin
            port_b_latch <= {2'b00, wr_byte[5:0]}; // [R1] [R3] [R9]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_direction <= `DIR_RESET; // [R5]
        end else if (wr_strobe && sel == gpio_ports_pkg::SEL_A_DIR) begin
            port_a_direction <= wr_byte; // [R6]
        end
    end

    // Bit 6 of the narrow direction register has no storage; bit 7 holds the slow-fall enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_direction <= `DIR_RESET; // [R2] [R5]
        end else if (wr_strobe && sel == gpio_ports_pkg::SEL_B_DIR) begin
            port_b_direction <= {wr_byte[7], 1'b0, wr_byte[5:0]}; // [R2] [R6] [R14]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_pull_disable <= `PULL_RESET; // [R20]
        end else if (wr_strobe && sel == gpio_ports_pkg::SEL_A_PULL) begin
            port_a_pull_disable <= wr_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_pull_disable <= `PULL_RESET; // [R12]
        end else if (wr_strobe && sel == gpio_ports_pkg::SEL_B_PULL) begin
            port_b_pull_disable <= {2'b00, wr_byte[5:0]};
        end
    end

    // Pull-disable reads return a fixed value, since software cannot trust them anyway.
    always_comb begin
        next_prdata = 8'h00;
        unique case (sel)
            gpio_ports_pkg::SEL_A_LATCH:
                next_prdata = data_view(port_a_latch, port_a_direction, pins_a);
            gpio_ports_pkg::SEL_B_LATCH:
                next_prdata = data_view(port_b_latch, {2'b00, port_b_direction[5:0]},
                    {2'b00, pins_b}); // [R1]
            gpio_ports_pkg::SEL_A_DIR:
                next_prdata = port_a_direction; // [R6]
            gpio_ports_pkg::SEL_B_DIR:
                next_prdata = port_b_direction; // [R2] [R6]
            gpio_ports_pkg::SEL_A_PULL:
                next_prdata = `PULL_READ_VALUE; // [R20]
            gpio_ports_pkg::SEL_B_PULL:
                next_prdata = `PULL_READ_VALUE; // [R12]
            gpio_ports_pkg::SEL_NONE:
                next_prdata = 8'h00;
        endcase
    end

    // Upper read bits are zero because every register is one byte wide.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_strobe) begin
            prdata <= {24'h000000, next_prdata};
        end
    end

    // Zero wait states: pready stands for exactly the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    // An unmapped or misaligned address is flagged; the decode already drops its write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_phase && sel == gpio_ports_pkg::SEL_NONE; // [R16]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_out <= 8'h00;
        end else begin
            port_a_out <= port_a_latch; // [R7] [R9]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_oe_n <= 8'hFF;
        end else begin
            port_a_oe_n <= ~port_a_direction; // [R4]
        end
    end

    // The second wide-sink line waits one extra cycle before it may fall, the
    // nearest whole-cycle stand-in for the half-cycle delay of the real pad.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_pending <= 1'b0;
        end else begin
            second_pending <= second_line_falling(slow_fall_enable, port_b_direction[2],
                port_b_latch[2], port_b_out[2]); // [R15]
        end
    end

    always_comb begin
        next_b_out = port_b_latch[5:0]; // [R7]
        next_b_oe_n = ~port_b_direction[5:0]; // [R4]
        if (second_line_falling(slow_fall_enable, port_b_direction[2], port_b_latch[2],
            port_b_out[2]) && !second_pending) begin
            next_b_out[2] = 1'b1; // [R15]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_out <= 6'h00;
        end else begin
            port_b_out <= next_b_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_oe_n <= 6'h3F;
        end else begin
            port_b_oe_n <= next_b_oe_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wide_port_line6_slow <= 1'b0;
            wide_port_line7_slow <= 1'b0;
            wide_sink_line_first_slow <= 1'b0;
        end else begin
            wide_port_line6_slow <= slow_fall_enable && port_a_direction[6]; // [R14]
            wide_port_line7_slow <= slow_fall_enable && port_a_direction[7]; // [R14]
            wide_sink_line_first_slow <= slow_fall_enable && port_b_direction[1]; // [R14] [R15]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_pull_up_en <= 8'h00;
            port_a_pull_down_en <= 8'h00;
        end else begin
            port_a_pull_up_en <= pull_up_mask(pull_option_enable, port_a_pull_disable,
                port_a_pull_is_up); // [R10] [R11] [R21]
            port_a_pull_down_en <= pull_down_mask(pull_option_enable, port_a_pull_disable,
                port_a_pull_is_up, port_a_direction); // [R10] [R11] [R21]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_pull_up_en <= 6'h00;
            port_b_pull_down_en <= 6'h00;
        end else begin
            port_b_pull_up_en <= b_pull_up_full[5:0]; // [R10] [R11] [R21]
            port_b_pull_down_en <= b_pull_down_full[5:0]; // [R10] [R11] [R21]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_capture_input <= 1'b0;
        end else begin
            timer_capture_input <= pins_b[0]; // [R17]
        end
    end
endmodule : dual_bidirectional_io_ports
`default_nettype wire

// ### rtl/gpio_ports_cfg.svh
`ifndef GPIO_PORTS_CFG_SVH
`define GPIO_PORTS_CFG_SVH

// Printed offsets include non-multiples of four, so they are indices; byte address is 4x.
`define IDX_A_LATCH 8'h00
`define IDX_B_LATCH 8'h01
`define IDX_A_DIR 8'h04
`define IDX_B_DIR 8'h05
`define IDX_A_PULL 8'h10
`define IDX_B_PULL 8'h11
`define B_WIDTH 6
`define B_SLOW_BIT 7
`define DIR_RESET 8'h00
`define PULL_RESET 8'h00
`define PULL_READ_VALUE 8'h00
`define T_CYC_NS 25
`define HALF_CYC_NS 13
`define CLK_PERIOD_NS 25
`define SECOND_FALL_DELAY ((`HALF_CYC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/gpio_ports_pkg.sv
`default_nettype none
package gpio_ports_pkg;
    typedef logic [7:0] port_byte_t;
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_A_LATCH = 3'b001,
        SEL_B_LATCH = 3'b010,
        SEL_A_DIR = 3'b011,
        SEL_B_DIR = 3'b100,
        SEL_A_PULL = 3'b101,
        SEL_B_PULL = 3'b110
    } reg_sel_t;
endpackage : gpio_ports_pkg
`default_nettype wire

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [13:0] raw,
    output logic [13:0] synced
);
    logic [13:0] stage1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= 14'h0000;
            synced <= 14'h0000;
        end else begin
            stage1 <= raw;
            synced <= stage1;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ### verif/gpio_ports_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pull_option_enable,
    input wire logic [7:0] port_a_pull_is_up,
    input wire logic [5:0] port_b_in,
    input wire logic [7:0] port_a_oe_n,
    input wire logic [5:0] port_b_oe_n,
    input wire logic [7:0] port_a_pull_down_en,
    input wire logic [7:0] port_a_pull_up_en,
    input wire logic [5:0] port_b_pull_down_en,
    input wire logic [5:0] port_b_pull_up_en,
    input wire logic wide_port_line6_slow,
    input wire logic wide_sink_line_first_slow,
    input wire logic timer_capture_input
);
    // Counts edges since reset so history checks never look back into reset.
    logic [2:0] up_cnt;
    logic rd_done;
    assign rd_done = pready && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_cnt <= 3'h0;
        else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
    end
    b_data_hi_a: assert property (rd_done && paddr == 32'h4 |-> prdata[31:6] == 26'h0)
        else $error("narrow data upper bits not zero");
    b_dir_hi_a: assert property (
        rd_done && paddr == 32'h14 |-> prdata[31:8] == 24'h0 && !prdata[6])
        else $error("narrow direction bit six not zero");
    dir_drive_a: assert property (
        psel && penable && pready && pwrite && paddr == 32'h10
        |-> ##2 port_a_oe_n == ~$past(pwdata[7:0], 2)) else $error("drive enable wrong");
    pd_input_a: assert property (
        (port_a_pull_down_en & (~port_a_oe_n | port_a_pull_is_up)) == 8'h0)
        else $error("pull-down on output or pull-up line");
    opt_off_a: assert property (!pull_option_enable [*2] |-> ({port_a_pull_down_en,
        port_a_pull_up_en, port_b_pull_down_en, port_b_pull_up_en} == 28'h0))
        else $error("pull active with option off");
    unmapped_a: assert property (psel && !penable && paddr == 32'h8 |=> pready && pslverr)
        else $error("unmapped access not flagged");
    reset_in_a: assert property (up_cnt == 3'h0 |-> &port_a_oe_n && &port_b_oe_n)
        else $error("line driving after reset");
    capture_a: assert property (
        up_cnt == 3'h7 |-> timer_capture_input == $past(port_b_in[0], 3))
        else $error("capture input not following line zero");
    slow_in_a: assert property (!(port_a_oe_n[6] && wide_port_line6_slow)
        && !(port_b_oe_n[1] && wide_sink_line_first_slow)) else $error("slow edge on input");
    cover property (rd_done && paddr == 32'h0);
    cover property (wide_port_line6_slow && wide_sink_line_first_slow);
    cover property (pready && pslverr);
endmodule : gpio_ports_chk
bind dual_bidirectional_io_ports gpio_ports_chk chk_u (.*);
`default_nettype wire

// ### verif/pin_board.sv
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    input wire logic pclk,
    input wire logic [13:0] drv,
    input wire logic [13:0] oe_n,
    input wire logic [13:0] pu,
    input wire logic [13:0] pd,
    input wire logic [13:0] ext_val,
    input wire logic [13:0] ext_en,
    output logic [13:0] pins
);
    logic flip = 1'b0;
    always @(posedge pclk) flip <= ~flip;
    // An undriven, unpulled line wanders, so a stale level never passes for a read.
    always_comb begin
        for (int i = 0; i < 14; i++) begin
            if (!oe_n[i]) pins[i] = drv[i];
            else if (ext_en[i]) pins[i] = ext_val[i];
            else if (pu[i]) pins[i] = 1'b1;
            else if (pd[i]) pins[i] = 1'b0;
            else pins[i] = flip ^ i[0];
        end
    end
endmodule : pin_board
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, pull_option_enable = 1'b1, timer_capture_input;
    logic wide_port_line6_slow, wide_port_line7_slow, wide_sink_line_first_slow;
    logic [7:0] port_a_pull_is_up = 8'hC0, port_a_in, port_a_out, port_a_oe_n;
    logic [7:0] port_a_pull_down_en, port_a_pull_up_en;
    logic [5:0] port_b_pull_is_up = 6'h06, port_b_in, port_b_out, port_b_oe_n;
    logic [5:0] port_b_pull_down_en, port_b_pull_up_en;
    logic [13:0] ext_val = 14'h0, ext_en = 14'h0, pins;
    int err_total = 0, checks = 0;
    assign port_a_in = pins[7:0];
    assign port_b_in = pins[13:8];
    dual_bidirectional_io_ports dut_u (.*);
    pin_board board_u (.pclk(pclk), .drv({port_b_out, port_a_out}),
        .oe_n({port_b_oe_n, port_a_oe_n}), .pu({port_b_pull_up_en, port_a_pull_up_en}),
        .pd({port_b_pull_down_en, port_a_pull_down_en}), .ext_val(ext_val),
        .ext_en(ext_en), .pins(pins));
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        output logic [31:0] r, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_total++;
            tally_and_finish();
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Pull-disable registers are only ever written whole, never read back and modified.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, idx, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        xfer(1'b0, idx, 8'h00, r, e);
        chk(r, exp);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask : settle
    task automatic reset_dut();
        presetn <= 1'b0;
        settle(10);
        presetn <= 1'b1;
    endtask : reset_dut
    task automatic s_reset();
        settle(3);
        chk(port_a_oe_n, 8'hFF);
        chk(port_b_oe_n, 6'h3F);
        rd(8'h04, 32'h0);
        rd(8'h05, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h11, 32'h0);
        chk(port_a_pull_down_en, 8'h3F);
        chk(port_b_pull_up_en, 6'h06);
        chk(port_b_pull_down_en, 6'h39);
    endtask : s_reset
    task automatic s_dir();
        wr(8'h00, 8'h11);
        wr(8'h01, 8'h01);
        wr(8'h04, 8'h5A);
        wr(8'h05, 8'h25);
        rd(8'h04, 32'h5A);
        rd(8'h05, 32'h25);
        settle(3);
        chk(port_a_oe_n, 8'hA5);
        chk(port_b_oe_n, 6'h1A);
        chk(port_a_pull_down_en, 8'h25);
        chk(port_a_pull_up_en, 8'hC0);
    endtask : s_dir
    task automatic s_latch();
        wr(8'h04, 8'hFF);
        wr(8'h00, 8'h96);
        settle(3);
        chk(port_a_out, 8'h96);
        rd(8'h00, 32'h96);
        reset_dut();
        wr(8'h04, 8'hFF);
        rd(8'h00, 32'h96);
        ext_en <= 14'h00FF;
        ext_val <= 14'h000F;
        wr(8'h04, 8'hF0);
        wr(8'h00, 8'h3C);
        settle(4);
        chk(port_a_oe_n, 8'h0F);
        rd(8'h00, 32'h3F);
        wr(8'h04, 8'hFF);
        rd(8'h00, 32'h3C);
    endtask : s_latch
    task automatic s_narrow();
        wr(8'h05, 8'hFF);
        rd(8'h05, 32'hBF);
        wr(8'h01, 8'hFF);
        rd(8'h01, 32'h3F);
        wr(8'h04, 8'hC0);
        settle(3);
        chk({wide_port_line6_slow, wide_port_line7_slow, wide_sink_line_first_slow}, 3'h7);
        wr(8'h01, 8'h00);
        @(posedge pclk);
        @(posedge pclk);
        chk(port_b_out[1], 1'b0);
        chk(port_b_out[2], 1'b1);
        @(posedge pclk);
        chk(port_b_out[2], 1'b0);
        wr(8'h05, 8'h80);
        wr(8'h04, 8'h00);
        settle(3);
        chk({wide_port_line6_slow, wide_port_line7_slow, wide_sink_line_first_slow}, 3'h0);
    endtask : s_narrow
    task automatic s_pull();
        wr(8'h04, 8'hFF);
        wr(8'h10, 8'h81);
        wr(8'h04, 8'h00);
        wr(8'h11, 8'h02);
        settle(3);
        chk(port_a_pull_down_en, 8'h3E);
        chk(port_a_pull_up_en, 8'h40);
        chk(port_b_pull_up_en, 6'h04);
        pull_option_enable <= 1'b0;
        settle(3);
        chk({port_a_pull_down_en, port_a_pull_up_en}, 16'h0);
        chk({port_b_pull_down_en, port_b_pull_up_en}, 12'h0);
        pull_option_enable <= 1'b1;
    endtask : s_pull
    // A write with its byte strobe low must leave the latch untouched.
    task automatic s_strobe();
        wr(8'h04, 8'hFF);
        wr(8'h00, 8'h5A);
        pstrb <= 4'h0;
        wr(8'h00, 8'hA5);
        pstrb <= 4'hF;
        rd(8'h00, 32'h5A);
    endtask : s_strobe
    task automatic s_decode();
        logic [31:0] r;
        logic e;
        xfer(1'b0, 8'h02, 8'h00, r, e);
        chk(e, 1'b1);
        wr(8'h05, 8'h00);
        ext_en <= 14'h0100;
        ext_val <= 14'h0100;
        settle(5);
        chk(timer_capture_input, 1'b1);
        ext_val <= 14'h0000;
        settle(5);
        chk(timer_capture_input, 1'b0);
    endtask : s_decode
    initial begin
        reset_dut();
        s_reset();
        s_dir();
        s_latch();
        s_narrow();
        s_pull();
        s_strobe();
        s_decode();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
